// file: src/pvc_pkg.sv
package pvc_pkg;
  // register numbers as the management frames count them; byte address is four times that
  localparam logic [4:0] IDX_PARTNER_NP = 5'h08;
  localparam logic [4:0] IDX_PLL_CTRL = 5'h10;
  localparam logic [4:0] IDX_AFE_CTRL = 5'h11;
  localparam logic [4:0] IDX_SYM_ERR = 5'h15;
  localparam logic [4:0] IDX_STRAP_OVR = 5'h16;
  localparam logic [4:0] IDX_EXP_CTRL = 5'h18;
  localparam logic [11:0] ADDR_PARTNER_NP = {5'h00, IDX_PARTNER_NP, 2'h0};
  localparam logic [11:0] ADDR_PLL_CTRL = {5'h00, IDX_PLL_CTRL, 2'h0};
  localparam logic [11:0] ADDR_AFE_CTRL = {5'h00, IDX_AFE_CTRL, 2'h0};
  localparam logic [11:0] ADDR_SYM_ERR = {5'h00, IDX_SYM_ERR, 2'h0};
  localparam logic [11:0] ADDR_STRAP_OVR = {5'h00, IDX_STRAP_OVR, 2'h0};
  localparam logic [11:0] ADDR_EXP_CTRL = {5'h00, IDX_EXP_CTRL, 2'h0};
  localparam int PLL_OFF_BIT = 4;
  localparam int SLOW_OSC_BIT = 5;
  localparam int FACTORY_BIT = 15;
  localparam int BCAST_OVR_BIT = 9;
  localparam int STRAP_RO_BIT = 10;
  localparam int ENERGY_DETECT_POWER_DOWN_DIS_BIT = 11;
  localparam logic [15:0] PLL_CTRL_RESET = 16'h0000;
  localparam logic [15:0] AFE_CTRL_RESET = 16'h0000;
  localparam logic [15:0] STRAP_OVR_RESET = 16'h0002;
  localparam logic [15:0] EXP_CTRL_RESET = 16'h0800;
  localparam logic [15:0] NP_MSG_MASK = 16'h07ff;
  localparam logic [15:0] STRAP_WR_MASK = 16'hfbff;
endpackage : pvc_pkg

// file: src/pvc_regs.sv
module pvc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [10:0] partner_np_msg,
  input wire logic symbol_error_frame,
  input wire logic receive_error_pin,
  input wire logic energy_detect_idle,
  output logic pll_power_off,
  output logic slow_osc_select,
  output logic analog_power_down,
  output logic energy_detect_power_down_en,
  output logic factory_test_mode,
  output logic addr0_broadcast_disable
);
  import pvc_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // bit 13 is a constant one that marks when stage b holds real pin levels
  logic [13:0] sync_a;
  logic [13:0] sync_b;
  logic sync_valid;
  logic strap_level;
  logic sym_level;
  logic [10:0] np_level;
  assign sync_valid = sync_b[13];
  assign strap_level = sync_b[12];
  assign sym_level = sync_b[11];
  assign np_level = sync_b[10:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 14'h0000;
      sync_b <= 14'h0000;
    end else begin
      sync_a <= {1'b1, receive_error_pin, symbol_error_frame, partner_np_msg};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // energy-detect idle synchroniser
  // ----------------------------------------
  logic edi_a;
  logic energy_idle_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edi_a <= 1'b0;
      energy_idle_s <= 1'b0;
    end else begin
      edi_a <= energy_detect_idle;
      energy_idle_s <= edi_a;
    end
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_en;
  logic rd_setup;
  logic hit;
  assign wr_en = psel && penable && pwrite;
  // reads are served from the setup cycle so that pready can follow one edge later
  assign rd_setup = psel && !penable && !pwrite;
  always_comb begin
    unique case (paddr)
      ADDR_PARTNER_NP, ADDR_PLL_CTRL, ADDR_AFE_CTRL, ADDR_SYM_ERR, ADDR_STRAP_OVR,
      ADDR_EXP_CTRL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [15:0] pll_ctrl;
  logic [15:0] afe_ctrl;
  logic [15:0] strap_ovr;
  logic [15:0] exp_ctrl;
  logic [15:0] sym_err;
  logic strap_done;
  logic wr_pll;
  logic wr_afe;
  logic wr_exp;
  logic wr_strap;
  assign wr_pll = wr_en && paddr == ADDR_PLL_CTRL;
  assign wr_afe = wr_en && paddr == ADDR_AFE_CTRL;
  assign wr_exp = wr_en && paddr == ADDR_EXP_CTRL;
  assign wr_strap = wr_en && paddr == ADDR_STRAP_OVR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_ctrl <= PLL_CTRL_RESET;
    end else if (wr_pll) begin
      pll_ctrl <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      afe_ctrl <= AFE_CTRL_RESET;
    end else if (wr_afe) begin
      afe_ctrl <= pwdata[15:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_ctrl <= EXP_CTRL_RESET;
    end else if (wr_exp) begin
      exp_ctrl <= pwdata[15:0];
    end
  end

  // strap taken once the synchroniser holds the pin level; a write before that is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_ovr <= STRAP_OVR_RESET;
      strap_done <= 1'b0;
    end else if (!strap_done) begin
      if (sync_valid) begin
        strap_done <= 1'b1;
        strap_ovr[FACTORY_BIT] <= strap_level;
      end
    end else if (wr_strap) begin
      strap_ovr <= pwdata[15:0] & STRAP_WR_MASK;
    end
  end

  // ----------------------------------------
  // symbol error counter, set wins over read clear
  // ----------------------------------------
  logic sym_pulse;
  logic sym_prev;
  logic sym_clear;
  assign sym_pulse = sym_level && !sym_prev;
  // cleared at the edge that copies the count into prdata, so no frame falls in between
  assign sym_clear = rd_setup && paddr == ADDR_SYM_ERR;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_prev <= 1'b0;
      sym_err <= 16'h0000;
    end else begin
      sym_prev <= sym_level;
      if (sym_clear) begin
        sym_err <= {15'h0000, sym_pulse};
      end else if (sym_pulse && sym_err != 16'hffff) begin
        sym_err <= sym_err + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // read path and outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= 32'h0000_0000;
      if (rd_setup) begin
        unique case (paddr)
          ADDR_PARTNER_NP: prdata <= {16'h0000, 16'(np_level) & NP_MSG_MASK};
          ADDR_PLL_CTRL: prdata <= {16'h0000, pll_ctrl};
          ADDR_AFE_CTRL: prdata <= {16'h0000, afe_ctrl};
          ADDR_SYM_ERR: prdata <= {16'h0000, sym_err};
          ADDR_STRAP_OVR: prdata <= {16'h0000, strap_ovr};
          ADDR_EXP_CTRL: prdata <= {16'h0000, exp_ctrl};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // control outputs
  // ----------------------------------------
  // pll off only while energy-detect power-down is enabled and the link is idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_power_off <= 1'b0;
    end else begin
      pll_power_off <= pll_ctrl[PLL_OFF_BIT] && !exp_ctrl[ENERGY_DETECT_POWER_DOWN_DIS_BIT] && energy_idle_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_osc_select <= 1'b0;
    end else begin
      slow_osc_select <= afe_ctrl[SLOW_OSC_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_power_down <= 1'b0;
    end else begin
      analog_power_down <= afe_ctrl[SLOW_OSC_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energy_detect_power_down_en <= 1'b0;
    end else begin
      energy_detect_power_down_en <= !exp_ctrl[ENERGY_DETECT_POWER_DOWN_DIS_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      factory_test_mode <= 1'b0;
    end else begin
      factory_test_mode <= strap_ovr[FACTORY_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr0_broadcast_disable <= 1'b0;
    end else begin
      addr0_broadcast_disable <= strap_ovr[BCAST_OVR_BIT];
    end
  end
endmodule : pvc_regs

// file: verif/pvc_regs_sva.sv
module pvc_regs_sva
  import pvc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pll_power_off,
  input wire logic slow_osc_select,
  input wire logic analog_power_down,
  input wire logic energy_detect_power_down_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // checks
  // ----
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer");
  a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("upper bits set");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error read data");
  a_np_width: assert property (pready && !pwrite && paddr == ADDR_PARTNER_NP
    |-> prdata[15:11] == 5'h00) else $error("message field wide");
  a_strap_ro: assert property (pready && !pwrite && paddr == ADDR_STRAP_OVR
    |-> !prdata[STRAP_RO_BIT]) else $error("fixed bit set");
  a_afe_power: assert property (slow_osc_select |-> analog_power_down)
    else $error("analog on");
  a_pll_energy_detect_power_down: assert property (pll_power_off |-> energy_detect_power_down_en)
    else $error("pll off outside mode");
  a_slow_write: assert property ($changed(slow_osc_select) |->
    $past(pready && pwrite && paddr == ADDR_AFE_CTRL) ||
    $past(pready && pwrite && paddr == ADDR_AFE_CTRL, 2)) else $error("osc change");
endmodule : pvc_regs_sva

bind pvc_regs pvc_regs_sva pvc_regs_sva_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pll_power_off, .slow_osc_select, .analog_power_down,
  .energy_detect_power_down_en);

// file: verif/pvc_phy_model.sv
module pvc_phy_model (
  input wire logic pclk,
  input wire logic frame_go,
  output logic symbol_error_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  // one errored frame every second cycle while frame_go is high
  always_ff @(posedge pclk) begin
    symbol_error_frame <= frame_go & ~symbol_error_frame;
  end
endmodule : pvc_phy_model

// file: verif/tb_phy_vendor_control_regs.sv
module tb_phy_vendor_control_regs;
  import pvc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, seed = 87;
  logic frame_go = 0, symbol_error_frame, receive_error_pin = 1, energy_detect_idle = 0;
  logic [10:0] partner_np_msg = 0;
  logic pll_power_off, slow_osc_select, analog_power_down, energy_detect_power_down_en;
  logic factory_test_mode, addr0_broadcast_disable;
  int mismatches = 0, cmp_count = 0;
  always #12.5 pclk = ~pclk;
  pvc_regs pvc_regs_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .partner_np_msg, .symbol_error_frame, .receive_error_pin,
    .energy_detect_idle, .pll_power_off, .slow_osc_select, .analog_power_down,
    .energy_detect_power_down_en, .factory_test_mode, .addr0_broadcast_disable);
  pvc_phy_model pvc_phy_model_inst (.pclk, .frame_go, .symbol_error_frame);
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t no pready", $time);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rd, e);
  endtask : rdchk
  initial begin
    logic [31:0] v;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rdchk(ADDR_EXP_CTRL, 32'h0800);
    rdchk(ADDR_PLL_CTRL, 32'h0);
    rdchk(ADDR_AFE_CTRL, 32'h0);
    rdchk(ADDR_SYM_ERR, 32'h0);
    rdchk(ADDR_PARTNER_NP, 32'h0);
    rdchk(ADDR_STRAP_OVR, 32'h8002);
    chk(factory_test_mode, 32'h1);
    $display("test reset values done");
    apb(1, ADDR_STRAP_OVR, 32'h0002);
    repeat (3) @(posedge pclk);
    chk(factory_test_mode, 32'h0);
    apb(1, ADDR_STRAP_OVR, 32'hffff);
    rdchk(ADDR_STRAP_OVR, 32'hfbff);
    chk(addr0_broadcast_disable, 32'h1);
    $display("test strap override done");
    for (int i = 0; i < 4; i++) begin
      v = xs();
      apb(1, ADDR_AFE_CTRL, v);
      rdchk(ADDR_AFE_CTRL, v[15:0]);
      chk(slow_osc_select, v[5]);
      chk(analog_power_down, v[5]);
      partner_np_msg <= v[26:16];
      apb(1, ADDR_PARTNER_NP, ~v);
      rdchk(ADDR_PARTNER_NP, v[26:16]);
    end
    $display("test random afe done");
    apb(1, ADDR_EXP_CTRL, 32'h0);
    apb(1, ADDR_PLL_CTRL, 32'h0010);
    energy_detect_idle <= 1;
    repeat (5) @(posedge pclk);
    chk(energy_detect_power_down_en, 32'h1);
    chk(pll_power_off, 32'h1);
    apb(1, ADDR_PLL_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk(pll_power_off, 32'h0);
    $display("test pll control done");
    frame_go <= 1;
    repeat (6) @(posedge pclk);
    frame_go <= 0;
    repeat (4) @(posedge pclk);
    rdchk(ADDR_SYM_ERR, 32'h3);
    rdchk(ADDR_SYM_ERR, 32'h0);
    $display("test error counter done");
    apb(0, 12'h0fc, 0);
    chk(err, 32'h1);
    chk(rd, 32'h0);
    $display("test bus error done");
    receive_error_pin <= 0;
    presetn <= 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    repeat (3) @(posedge pclk);
    rdchk(ADDR_STRAP_OVR, 32'h0002);
    chk(factory_test_mode, 32'h0);
    chk(addr0_broadcast_disable, 32'h0);
    rdchk(ADDR_AFE_CTRL, 32'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_phy_vendor_control_regs
